// >>> logic/rapi_consts.svh
// constants for the radio api frame ends
`ifndef RAPI_CONSTS_SVH
`define RAPI_CONSTS_SVH
`define RAPI_START        8'h7E
`define RAPI_T_TX16       8'h01
`define RAPI_T_TX64       8'h00
`define RAPI_T_STAT       8'h89
`define RAPI_T_RX64       8'h80
`define RAPI_T_RX16       8'h81
`define RAPI_BCAST16      16'hFFFF
`define RAPI_OPT_NOACK    8'h01
`define RAPI_OPT_BPAN     8'h04
`define RAPI_OPT_MASK     8'h05
`define RAPI_RXO_ABC      8'h02
`define RAPI_RXO_PBC      8'h04
`define RAPI_RXO_MASK     8'h06
`define RAPI_MAX_TX16     8'h74
`define RAPI_MAX_RX64     8'h6E
`define RAPI_MAX_RX16     8'h74
`define RAPI_ST_OK        8'h00
`define RAPI_ST_NOACK     8'h01
`define RAPI_ST_CCA       8'h02
`define RAPI_ST_PURGE     8'h03
`define RAPI_ST_NACK      8'h21
`define RAPI_ST_NOJOIN    8'h22
`define RAPI_ST_INTERR    8'h31
`define RAPI_ST_NORES     8'h32
`define RAPI_ST_BIG       8'h74
`define RAPI_RETRIES      4'h3
`define RAPI_HDR_TX16     8'h05
`define RAPI_HDR_RX64     8'h0B
`define RAPI_HDR_RX16     8'h05
`define RAPI_STAT_LEN     8'h03
`define RAPI_FF           8'hFF
`define RAPI_IX_TYPE      8'h00
`define RAPI_IX_FID       8'h01
`define RAPI_IX_DMSB      8'h02
`define RAPI_IX_DLSB      8'h03
`define RAPI_IX_OPT       8'h04
`define RAPI_RSSI_RX64    8'h09
`define RAPI_RSSI_RX16    8'h03
`endif

// >>> logic/rapi_dev.sv
// radio side: parses tx requests, emits status and receive frames
`timescale 1ns/10ps
`include "rapi_consts.svh"
module rapi_dev
	import rapi_pkg::*;
(
	input  wire logic  CLK,
	input  wire logic  RST_N,
	rapi_if.dev        LINK,
	output logic       TX_REQ,
	output logic [15:0] TX_DEST,
	output logic       TX_NOACK,
	output logic       TX_BPAN,
	output logic [7:0] TX_LEN,
	output logic [7:0] TX_DATA,
	output logic       TX_DATA_VLD,
	input  wire logic  TX_DONE,
	input  wire rapi_res_e TX_RES,
	input  wire logic [7:0] TX_OTHER_CODE,
	output logic       TX_BUSY,
	input  wire logic  RX_START,
	input  wire logic  RX_LONG,
	input  wire logic [63:0] RX_SRC,
	input  wire logic [7:0] RX_RSSI,
	input  wire logic [7:0] RX_OPT,
	input  wire logic [7:0] RX_LEN,
	input  wire logic [7:0] RX_DATA,
	output logic       RX_DATA_REQ,
	output logic       RX_BUSY
);
	typedef enum logic [2:0] {I_IDLE, I_LEN1, I_LEN2, I_BODY, I_SUM}
		rapi_in_e;
	typedef enum logic [1:0] {O_IDLE, O_HDR, O_PAY, O_SUM} rapi_out_e;
	typedef struct packed {
		rapi_in_e   ist;
		logic [7:0] ilen;
		logic [7:0] icnt;
		logic [7:0] isum;
		logic [7:0] itype;
		logic [7:0] fid;
		logic [15:0] dest;
		logic [7:0] opt;
		logic       bad;
		logic       tx_req;
		logic       tx_vld;
		logic [7:0] tx_data;
		logic       tx_busy;
		logic       bcast;
		logic       st_pend;
		logic [7:0] st_code;
		rapi_out_e  ost;
		logic       o_stat;
		logic [7:0] ocnt;
		logic [7:0] olen;
		logic [7:0] osum;
		logic [7:0] odata;
		logic       ovld;
		logic       rx_req;
		logic       rx_busy;
		logic [7:0] rx_plen;
		logic [7:0] tx_len;
		logic       rx_long;
	} rapi_dst_s;
	rapi_dst_s s_ff, nxt_s;

	// receive header byte count: type, source, rssi, options
	function automatic logic [7:0] hdr_len(input logic lng);
		hdr_len = lng ? `RAPI_HDR_RX64 : `RAPI_HDR_RX16;
	endfunction : hdr_len

	// header byte of outgoing frame at body index i
	function automatic logic [7:0] out_hdr(input rapi_dst_s s,
		input logic lng, input logic [7:0] i);
		logic [7:0] rssi_i;
		out_hdr = 8'h00;
		rssi_i = lng ? `RAPI_RSSI_RX64 : `RAPI_RSSI_RX16;
		if (s.o_stat) begin
			unique case (i)
				`RAPI_IX_TYPE: out_hdr = `RAPI_T_STAT;
				`RAPI_IX_FID: out_hdr = s.fid;
				default: out_hdr = s.st_code;
			endcase
		end else if (i == 8'h00) begin
			out_hdr = lng ? `RAPI_T_RX64 : `RAPI_T_RX16;
		end else if (i < rssi_i) begin
			out_hdr = RX_SRC[8'(rssi_i - i - 8'h01) * 8 +: 8];
		end else if (i == rssi_i) begin
			out_hdr = RX_RSSI;
		end else begin
			out_hdr = RX_OPT & `RAPI_RXO_MASK;
		end
	endfunction : out_hdr

	logic [7:0] b;

	// next state of parser, status reporter and output framer
	always_comb begin
		nxt_s = s_ff;
		b = LINK.h2d_data;
		nxt_s.tx_req = 1'b0;
		nxt_s.tx_vld = 1'b0;
		nxt_s.ovld = 1'b0;
		nxt_s.rx_req = 1'b0;
		// inbound frame parse
		if (LINK.h2d_valid) begin
			unique case (s_ff.ist)
				I_IDLE: if (b == `RAPI_START) nxt_s.ist = I_LEN1;
				I_LEN1: nxt_s.ist = I_LEN2;
				I_LEN2: begin
					nxt_s.ilen = b;
					nxt_s.tx_len = 8'(b - `RAPI_HDR_TX16);
					nxt_s.icnt = 8'h00;
					nxt_s.isum = 8'h00;
					nxt_s.bad = s_ff.tx_busy;
					nxt_s.ist = (b == 8'h00) ? I_IDLE : I_BODY;
				end
				I_BODY: begin
					nxt_s.isum = 8'(s_ff.isum + b);
					nxt_s.icnt = 8'(s_ff.icnt + 8'h01);
					unique case (s_ff.icnt)
						`RAPI_IX_TYPE: begin
							nxt_s.itype = b;
							if (b != `RAPI_T_TX16) nxt_s.bad = 1'b1;
						end
						`RAPI_IX_FID: nxt_s.fid = b;
						`RAPI_IX_DMSB: nxt_s.dest[15:8] = b;
						`RAPI_IX_DLSB: nxt_s.dest[7:0] = b;
						`RAPI_IX_OPT: nxt_s.opt = b & `RAPI_OPT_MASK;
						default: begin
							nxt_s.tx_vld = ~s_ff.bad;
							nxt_s.tx_data = b;
						end
					endcase
					if (8'(s_ff.icnt + 8'h01) == s_ff.ilen) nxt_s.ist = I_SUM;
				end
				I_SUM: begin
					nxt_s.ist = I_IDLE;
					if (8'(s_ff.isum + b) == `RAPI_FF && !s_ff.bad) begin
						nxt_s.bcast = (s_ff.dest == `RAPI_BCAST16);
						if (8'(s_ff.ilen - `RAPI_HDR_TX16) >
							`RAPI_MAX_TX16) begin
							nxt_s.st_code = `RAPI_ST_BIG;
							nxt_s.st_pend = (s_ff.fid != 8'h00);
						end else begin
							nxt_s.tx_req = 1'b1;
							nxt_s.tx_busy = 1'b1;
						end
					end
				end
				default: nxt_s.ist = I_IDLE;
			endcase
		end
		// radio finished the request: choose status code
		if (s_ff.tx_busy && TX_DONE) begin
			nxt_s.tx_busy = 1'b0;
			nxt_s.st_pend = (s_ff.fid != 8'h00);
			unique case (TX_RES)
				RAPI_RES_OK: nxt_s.st_code = `RAPI_ST_OK;
				RAPI_RES_NOACK: nxt_s.st_code = s_ff.bcast ?
					`RAPI_ST_OK : `RAPI_ST_NOACK;
				RAPI_RES_CCA: nxt_s.st_code = `RAPI_ST_CCA;
				RAPI_RES_OTHER: nxt_s.st_code = (s_ff.bcast &&
					TX_OTHER_CODE == `RAPI_ST_NACK) ?
					`RAPI_ST_OK : TX_OTHER_CODE;
			endcase
		end
		// outbound framer, status frames first
		unique case (s_ff.ost)
			O_IDLE: begin
				if (s_ff.st_pend) begin
					nxt_s.o_stat = 1'b1;
					nxt_s.st_pend = 1'b0;
					nxt_s.olen = `RAPI_STAT_LEN;
				end else if (RX_START) begin
					nxt_s.o_stat = 1'b0;
					nxt_s.rx_busy = 1'b1;
					nxt_s.rx_long = RX_LONG;
					nxt_s.rx_plen = RX_LEN > (RX_LONG ? `RAPI_MAX_RX64 :
						`RAPI_MAX_RX16) ? (RX_LONG ? `RAPI_MAX_RX64 :
						`RAPI_MAX_RX16) : RX_LEN;
					nxt_s.olen = 8'(hdr_len(RX_LONG) + nxt_s.rx_plen);
				end
				if (s_ff.st_pend || RX_START) begin
					nxt_s.odata = `RAPI_START;
					nxt_s.ovld = 1'b1;
					nxt_s.ocnt = 8'h00;
					nxt_s.osum = 8'h00;
					nxt_s.ost = O_HDR;
				end
			end
			O_HDR: begin
				nxt_s.ovld = 1'b1;
				nxt_s.ocnt = 8'(s_ff.ocnt + 8'h01);
				if (s_ff.ocnt == 8'h00) nxt_s.odata = 8'h00;
				else if (s_ff.ocnt == 8'h01) nxt_s.odata = s_ff.olen;
				else begin
					nxt_s.odata = out_hdr(s_ff, s_ff.rx_long,
						8'(s_ff.ocnt - 8'h02));
					nxt_s.osum = 8'(s_ff.osum + nxt_s.odata);
				end
				if (8'(s_ff.ocnt - 8'h01) == s_ff.olen - (s_ff.o_stat ?
					8'h00 : s_ff.rx_plen)) begin
					nxt_s.ost = (s_ff.o_stat || s_ff.rx_plen == 8'h00) ?
						O_SUM : O_PAY;
					nxt_s.rx_req = ~nxt_s.o_stat && s_ff.rx_plen != 8'h00;
				end
			end
			O_PAY: begin
				nxt_s.ovld = 1'b1;
				nxt_s.odata = RX_DATA;
				nxt_s.osum = 8'(s_ff.osum + RX_DATA);
				nxt_s.ocnt = 8'(s_ff.ocnt + 8'h01);
				nxt_s.rx_req = 8'(s_ff.ocnt - 8'h01) != s_ff.olen;
				if (8'(s_ff.ocnt - 8'h01) == s_ff.olen) nxt_s.ost = O_SUM;
			end
			O_SUM: begin
				nxt_s.ovld = 1'b1;
				nxt_s.odata = 8'(`RAPI_FF - s_ff.osum);
				nxt_s.rx_busy = 1'b0;
				nxt_s.ost = O_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign LINK.d2h_data = s_ff.odata;
	assign LINK.d2h_valid = s_ff.ovld;
	assign TX_REQ = s_ff.tx_req;
	assign TX_DEST = s_ff.dest;
	assign TX_NOACK = s_ff.opt[0];
	assign TX_BPAN = s_ff.opt[2];
	assign TX_LEN = s_ff.tx_len;
	assign TX_DATA = s_ff.tx_data;
	assign TX_DATA_VLD = s_ff.tx_vld;
	assign TX_BUSY = s_ff.tx_busy;
	assign RX_DATA_REQ = s_ff.rx_req;
	assign RX_BUSY = s_ff.rx_busy;
endmodule : rapi_dev

// >>> logic/rapi_host.sv
// host side: frames tx requests and decodes incoming frames
`timescale 1ns/10ps
`include "rapi_consts.svh"
module rapi_host
	import rapi_pkg::*;
(
	input  wire logic  CLK,
	input  wire logic  RST_N,
	rapi_if.host       LINK,
	input  wire logic  REQ,
	input  wire logic [7:0] REQ_FID,
	input  wire logic [15:0] REQ_DEST,
	input  wire logic [7:0] REQ_OPT,
	input  wire logic [7:0] REQ_LEN,
	input  wire logic [7:0] REQ_DATA,
	output logic       REQ_DATA_RD,
	output logic       REQ_BUSY,
	output logic       EV_VLD,
	output logic [7:0] EV_TYPE,
	output logic [7:0] EV_BYTE,
	output logic [7:0] EV_IDX,
	output logic       EV_END,
	output logic       EV_OK
);
	typedef enum logic [2:0] {H_IDLE, H_L1, H_L2, H_BODY, H_SUM} rapi_hst_e;
	typedef struct packed {
		rapi_hst_e  tst;
		logic [7:0] tcnt;
		logic [7:0] tlen;
		logic [7:0] tsum;
		logic [7:0] fid;
		logic [15:0] dest;
		logic [7:0] opt;
		logic [7:0] odata;
		logic       ovld;
		logic       rd;
		rapi_hst_e  rst;
		logic [7:0] rlen;
		logic [7:0] rcnt;
		logic [7:0] rsum;
		logic [7:0] rtype;
		logic       ev;
		logic [7:0] ev_b;
		logic [7:0] ev_i;
		logic       ev_end;
		logic       ev_ok;
		logic       busy;
	} rapi_hst_s;
	rapi_hst_s s_ff, nxt_s;
	logic [7:0] plen;
	logic [7:0] hb;

	// next state of request framer and frame decoder
	always_comb begin
		nxt_s = s_ff;
		nxt_s.ovld = 1'b0;
		nxt_s.rd = 1'b0;
		nxt_s.ev = 1'b0;
		nxt_s.ev_end = 1'b0;
		plen = REQ_LEN > `RAPI_MAX_TX16 ? `RAPI_MAX_TX16 : REQ_LEN;
		hb = 8'h00;
		unique case (s_ff.tcnt)
			`RAPI_IX_TYPE: hb = `RAPI_T_TX16;
			`RAPI_IX_FID: hb = s_ff.fid;
			`RAPI_IX_DMSB: hb = s_ff.dest[15:8];
			`RAPI_IX_DLSB: hb = s_ff.dest[7:0];
			`RAPI_IX_OPT: hb = s_ff.opt;
			default: hb = REQ_DATA;
		endcase
		unique case (s_ff.tst)
			H_IDLE: if (REQ) begin
				nxt_s.fid = REQ_FID;
				nxt_s.dest = REQ_DEST;
				nxt_s.opt = REQ_OPT & `RAPI_OPT_MASK;
				nxt_s.tlen = 8'(plen + `RAPI_HDR_TX16);
				nxt_s.odata = `RAPI_START;
				nxt_s.ovld = 1'b1;
				nxt_s.tst = H_L1;
			end
			H_L1: begin
				nxt_s.odata = 8'h00;
				nxt_s.ovld = 1'b1;
				nxt_s.tst = H_L2;
			end
			H_L2: begin
				nxt_s.odata = s_ff.tlen;
				nxt_s.ovld = 1'b1;
				nxt_s.tcnt = 8'h00;
				nxt_s.tsum = 8'h00;
				nxt_s.tst = H_BODY;
			end
			H_BODY: begin
				nxt_s.odata = hb;
				nxt_s.ovld = 1'b1;
				nxt_s.rd = s_ff.tcnt >= `RAPI_HDR_TX16;
				nxt_s.tsum = 8'(s_ff.tsum + hb);
				nxt_s.tcnt = 8'(s_ff.tcnt + 8'h01);
				if (8'(s_ff.tcnt + 8'h01) == s_ff.tlen) nxt_s.tst = H_SUM;
			end
			default: begin
				nxt_s.odata = 8'(`RAPI_FF - s_ff.tsum);
				nxt_s.ovld = 1'b1;
				nxt_s.tst = H_IDLE;
			end
		endcase
		// busy flag registered so the output comes from a flop
		nxt_s.busy = nxt_s.tst != H_IDLE;
		// incoming frame decode
		if (LINK.d2h_valid) begin
			unique case (s_ff.rst)
				H_IDLE: if (LINK.d2h_data == `RAPI_START) nxt_s.rst = H_L1;
				H_L1: nxt_s.rst = H_L2;
				H_L2: begin
					nxt_s.rlen = LINK.d2h_data;
					nxt_s.rcnt = 8'h00;
					nxt_s.rsum = 8'h00;
					nxt_s.rst = (LINK.d2h_data == 8'h00) ? H_IDLE : H_BODY;
				end
				H_BODY: begin
					if (s_ff.rcnt == 8'h00) nxt_s.rtype = LINK.d2h_data;
					nxt_s.ev = 1'b1;
					nxt_s.ev_b = LINK.d2h_data;
					nxt_s.ev_i = s_ff.rcnt;
					nxt_s.rsum = 8'(s_ff.rsum + LINK.d2h_data);
					nxt_s.rcnt = 8'(s_ff.rcnt + 8'h01);
					if (8'(s_ff.rcnt + 8'h01) == s_ff.rlen) nxt_s.rst = H_SUM;
				end
				default: begin
					nxt_s.ev_end = 1'b1;
					nxt_s.ev_ok = 8'(s_ff.rsum + LINK.d2h_data) == `RAPI_FF;
					nxt_s.rst = H_IDLE;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge CLK) begin
		if (!RST_N) s_ff <= '0;
		else s_ff <= nxt_s;
	end

	assign LINK.h2d_data = s_ff.odata;
	assign LINK.h2d_valid = s_ff.ovld;
	assign REQ_DATA_RD = s_ff.rd;
	assign REQ_BUSY = s_ff.busy;
	assign EV_VLD = s_ff.ev;
	assign EV_TYPE = s_ff.rtype;
	assign EV_BYTE = s_ff.ev_b;
	assign EV_IDX = s_ff.ev_i;
	assign EV_END = s_ff.ev_end;
	assign EV_OK = s_ff.ev_ok;
endmodule : rapi_host

// >>> logic/rapi_if.sv
// serial byte link between host and radio module
`timescale 1ns/10ps
interface rapi_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic [7:0] d2h_data;
	logic       d2h_valid;
	modport host (output h2d_data, output h2d_valid,
		input d2h_data, input d2h_valid);
	modport dev (input h2d_data, input h2d_valid,
		output d2h_data, output d2h_valid);
endinterface : rapi_if

// >>> logic/rapi_pkg.sv
// types shared by the radio api frame ends
package rapi_pkg;
	typedef logic [7:0] rapi_byte_t;
	typedef enum logic [1:0] {
		RAPI_RES_OK,
		RAPI_RES_NOACK,
		RAPI_RES_CCA,
		RAPI_RES_OTHER
	} rapi_res_e;
endpackage : rapi_pkg

// >>> tb/rapi_checker.sv
// link protocol assertions for the host and device frame ends
`timescale 1ns/10ps
module rapi_checker (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_valid,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_valid
);
	logic [7:0] hp_ff, hl_ff, hs_ff, dp_ff, dl_ff, ds_ff, dt_ff;
	default clocking rapi_cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// frame position, length and running sum per direction, frame type for d2h only
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			{hp_ff, hl_ff, hs_ff, dp_ff, dl_ff, ds_ff, dt_ff} <= '0;
		end else begin
			if (h2d_valid) begin
				hp_ff <= (hp_ff > 2 && hp_ff == hl_ff + 8'h03) ? 8'h00
					: 8'(hp_ff + 8'h01);
				hl_ff <= (hp_ff == 8'h02) ? h2d_data : hl_ff;
				hs_ff <= (hp_ff == 8'h03) ? h2d_data : hs_ff + h2d_data;
			end
			if (d2h_valid) begin
				dp_ff <= (dp_ff > 2 && dp_ff == dl_ff + 8'h03) ? 8'h00
					: 8'(dp_ff + 8'h01);
				dl_ff <= (dp_ff == 8'h02) ? d2h_data : dl_ff;
				ds_ff <= (dp_ff == 8'h03) ? d2h_data : ds_ff + d2h_data;
				dt_ff <= (dp_ff == 8'h03) ? d2h_data : dt_ff;
			end
		end
	end
	property p_h_start;
		h2d_valid && hp_ff < 2 |-> h2d_data == (hp_ff == 0 ? 8'h7E : 8'h00);
	endproperty
	a_h_start: assert property (p_h_start) else $error("bad tx head");
	property p_h_len;
		h2d_valid && hp_ff == 2 |-> h2d_data inside {[8'h05:8'h79]};
	endproperty
	a_h_len: assert property (p_h_len) else $error("bad tx length");
	property p_h_type;
		h2d_valid && hp_ff == 3 |-> h2d_data == 8'h01;
	endproperty
	a_h_type: assert property (p_h_type) else $error("bad tx type");
	property p_h_opt;
		h2d_valid && hp_ff == 7 |-> (h2d_data & 8'hFA) == 8'h00;
	endproperty
	a_h_opt: assert property (p_h_opt) else $error("bad tx options");
	property p_h_sum;
		h2d_valid && hp_ff > 2 && hp_ff == hl_ff + 8'h03
			|-> 8'(hs_ff + h2d_data) == 8'hFF;
	endproperty
	a_h_sum: assert property (p_h_sum) else $error("bad tx checksum");
	property p_d_start;
		d2h_valid && dp_ff < 2 |-> d2h_data == (dp_ff == 0 ? 8'h7E : 8'h00);
	endproperty
	a_d_start: assert property (p_d_start) else $error("bad head");
	property p_d_type;
		d2h_valid && dp_ff == 3 |-> d2h_data inside {8'h89, 8'h80, 8'h81};
	endproperty
	a_d_type: assert property (p_d_type) else $error("bad type");
	property p_d_len;
		d2h_valid && dp_ff == 3 |-> (d2h_data == 8'h89) ? dl_ff == 8'h03
			: dl_ff <= 8'h79;
	endproperty
	a_d_len: assert property (p_d_len) else $error("bad length");
	property p_d_fid;
		d2h_valid && dp_ff == 4 && dt_ff == 8'h89 |-> d2h_data != 8'h00;
	endproperty
	a_d_fid: assert property (p_d_fid) else $error("status for id 0");
	property p_d_code;
		d2h_valid && dp_ff == 5 && dt_ff == 8'h89 |-> d2h_data inside
			{[8'h00:8'h03], 8'h21, 8'h22, 8'h31, 8'h32, 8'h74};
	endproperty
	a_d_code: assert property (p_d_code) else $error("bad code");
	property p_d_opt;
		d2h_valid && ((dp_ff == 13 && dt_ff == 8'h80)
			|| (dp_ff == 7 && dt_ff == 8'h81)) |-> (d2h_data & 8'hF9) == 8'h00;
	endproperty
	a_d_opt: assert property (p_d_opt) else $error("bad rx options");
	property p_d_sum;
		d2h_valid && dp_ff > 2 && dp_ff == dl_ff + 8'h03
			|-> 8'(ds_ff + d2h_data) == 8'hFF;
	endproperty
	a_d_sum: assert property (p_d_sum) else $error("bad checksum");
endmodule : rapi_checker

// >>> tb/tb_radio_api_data_frames.sv
// bench joining host and device frame ends over the byte link
`timescale 1ns/10ps
module tb_radio_api_data_frames;
	import rapi_pkg::*;
	typedef struct {logic [7:0] fid; logic [15:0] dst; logic [7:0] opt, len;
		rapi_res_e res; logic [7:0] code, st;} rapi_row_s;
	logic        CLK, RST_N, REQ, REQ_DATA_RD, REQ_BUSY, EV_VLD, EV_END, EV_OK;
	logic        TX_REQ, TX_NOACK, TX_BPAN, TX_DATA_VLD, TX_DONE, TX_BUSY;
	logic        RX_START, RX_LONG, RX_DATA_REQ, RX_BUSY, seen, ok;
	logic [7:0]  REQ_FID, REQ_OPT, REQ_LEN, REQ_DATA, EV_TYPE, EV_BYTE, EV_IDX;
	logic [7:0]  TX_LEN, TX_DATA, TX_OTHER_CODE, RX_RSSI, RX_OPT, RX_LEN, RX_DATA;
	logic [15:0] REQ_DEST, TX_DEST;
	logic [63:0] RX_SRC;
	rapi_res_e   TX_RES;
	logic [7:0]  evq [$];
	int          k, nb, rp, cyc, error_cnt, check_count;
	rapi_row_s   rows [11] = '{
		'{8'h01, 16'h1234, 8'h00, 8'h03, RAPI_RES_OK, 8'h00, 8'h00},
		'{8'h02, 16'h1234, 8'h01, 8'h00, RAPI_RES_NOACK, 8'h00, 8'h01},
		'{8'h03, 16'h5678, 8'h04, 8'h01, RAPI_RES_CCA, 8'h00, 8'h02},
		'{8'h04, 16'h0001, 8'h00, 8'h02, RAPI_RES_OTHER, 8'h03, 8'h03},
		'{8'h05, 16'h0002, 8'h00, 8'h02, RAPI_RES_OTHER, 8'h21, 8'h21},
		'{8'h06, 16'h0003, 8'h00, 8'h02, RAPI_RES_OTHER, 8'h22, 8'h22},
		'{8'h07, 16'h0004, 8'h00, 8'h02, RAPI_RES_OTHER, 8'h31, 8'h31},
		'{8'h08, 16'h0005, 8'h00, 8'h02, RAPI_RES_OTHER, 8'h32, 8'h32},
		'{8'hFF, 16'hFFFF, 8'hFF, 8'h78, RAPI_RES_NOACK, 8'h00, 8'h00},
		'{8'h0A, 16'hFFFF, 8'h00, 8'h04, RAPI_RES_OTHER, 8'h21, 8'h00},
		'{8'h00, 16'h1234, 8'h00, 8'h02, RAPI_RES_OK, 8'h00, 8'h00}};
	rapi_if rapi_if_i ();
	rapi_host rapi_host_i (.CLK(CLK), .RST_N(RST_N), .LINK(rapi_if_i),
		.REQ(REQ), .REQ_FID(REQ_FID), .REQ_DEST(REQ_DEST),
		.REQ_OPT(REQ_OPT), .REQ_LEN(REQ_LEN), .REQ_DATA(REQ_DATA),
		.REQ_DATA_RD(REQ_DATA_RD), .REQ_BUSY(REQ_BUSY),
		.EV_VLD(EV_VLD), .EV_TYPE(EV_TYPE), .EV_BYTE(EV_BYTE),
		.EV_IDX(EV_IDX), .EV_END(EV_END), .EV_OK(EV_OK));
	rapi_dev rapi_dev_i (.CLK(CLK), .RST_N(RST_N), .LINK(rapi_if_i),
		.TX_REQ(TX_REQ), .TX_DEST(TX_DEST), .TX_NOACK(TX_NOACK),
		.TX_BPAN(TX_BPAN), .TX_LEN(TX_LEN), .TX_DATA(TX_DATA),
		.TX_DATA_VLD(TX_DATA_VLD), .TX_DONE(TX_DONE), .TX_RES(TX_RES),
		.TX_OTHER_CODE(TX_OTHER_CODE), .TX_BUSY(TX_BUSY),
		.RX_START(RX_START), .RX_LONG(RX_LONG), .RX_SRC(RX_SRC),
		.RX_RSSI(RX_RSSI), .RX_OPT(RX_OPT), .RX_LEN(RX_LEN),
		.RX_DATA(RX_DATA), .RX_DATA_REQ(RX_DATA_REQ), .RX_BUSY(RX_BUSY));
	rapi_checker rapi_checker_i (.CLK(CLK), .RST_N(RST_N),
		.h2d_data(rapi_if_i.h2d_data), .h2d_valid(rapi_if_i.h2d_valid),
		.d2h_data(rapi_if_i.d2h_data), .d2h_valid(rapi_if_i.d2h_valid));
	assign REQ_DATA = 8'h30 + k[7:0];
	task automatic chk(string nm, logic [15:0] seen_v, logic [15:0] exp);
		check_count++;
		if (seen_v !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen_v);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	// clock and hang guard
	initial begin
		CLK = 0;
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	// payload feeders and event collector, all off the falling edge
	always @(negedge CLK) begin
		if (REQ_DATA_RD) k++;
		if (RX_DATA_REQ) begin
			RX_DATA = 8'hA0 + rp[7:0];
			rp++;
		end
		if (TX_DATA_VLD) begin
			chk("tx byte", TX_DATA, 8'h30 + nb[7:0]);
			nb++;
		end
		if (EV_VLD) begin
			chk("ev idx", EV_IDX, 16'(evq.size()));
			evq.push_back(EV_BYTE);
		end
		if (EV_END) {seen, ok} = {1'b1, EV_OK};
	end
	task automatic idle_wait();
		for (int n = 0; n < 60 && (REQ_BUSY | TX_BUSY | RX_BUSY) !== 1'b0; n++)
			@(negedge CLK);
		evq.delete();
		seen = 1'b0;
	endtask : idle_wait
	task automatic cmp_frame(logic [7:0] q [$]);
		for (int n = 0; n < 300 && !seen; n++) @(negedge CLK);
		chk("count", 16'(evq.size()), 16'(q.size()));
		chk("type", EV_TYPE, q[0]);
		chk("sum ok", ok, 1'b1);
		foreach (q[i]) chk("byte", evq[i], q[i]);
	endtask : cmp_frame
	task automatic tx(rapi_row_s r);
		logic [7:0] ln;
		ln = (r.len > 8'd116) ? 8'd116 : r.len;
		idle_wait();
		{k, nb} = 0;
		{REQ, REQ_FID, REQ_DEST, REQ_OPT, REQ_LEN} = {1'b1, r.fid, r.dst, r.opt, r.len};
		@(negedge CLK);
		REQ = 0;
		for (int n = 0; n < 300 && TX_REQ !== 1'b1; n++) @(negedge CLK);
		chk("dest", TX_DEST, r.dst);
		chk("noack", TX_NOACK, r.opt[0]);
		chk("pan", TX_BPAN, r.opt[2]);
		chk("len", TX_LEN, ln);
		chk("bytes", nb[15:0], ln);
		chk("busy", TX_BUSY, 1'b1);
		TX_RES = r.res;
		{TX_OTHER_CODE, TX_DONE} = {r.code, 1'b1};
		@(negedge CLK);
		TX_DONE = 0;
		if (r.fid == 8'h00) begin
			repeat (40) @(negedge CLK);
			chk("silent", 16'(evq.size()), 16'h0000);
		end else begin
			cmp_frame({8'h89, r.fid, r.st});
		end
		$display("tx test %h done", r.fid);
	endtask : tx
	task automatic rx(logic lng, logic [63:0] src, logic [7:0] rs, op, ln);
		logic [7:0] q [$];
		int m;
		m = lng ? (ln > 110 ? 110 : ln) : (ln > 116 ? 116 : ln);
		q = {lng ? 8'h80 : 8'h81};
		for (int n = lng ? 7 : 1; n >= 0; n--) q.push_back(src[n*8 +: 8]);
		q = {q, rs, op & 8'h06};
		for (int n = 0; n < m; n++) q.push_back(8'hA0 + 8'(n));
		idle_wait();
		rp = 0;
		{RX_START, RX_LONG, RX_SRC, RX_RSSI, RX_OPT, RX_LEN} = {1'b1, lng, src, rs, op, ln};
		@(negedge CLK);
		RX_START = 0;
		cmp_frame(q);
		$display("rx test %b done", lng);
	endtask : rx
	// reset, table of requests, then receive and reset cases
	initial begin
		{RST_N, REQ, REQ_FID, REQ_DEST, REQ_OPT, REQ_LEN, TX_DONE} = '0;
		{TX_OTHER_CODE, RX_START, RX_LONG, RX_SRC, RX_RSSI, RX_OPT} = '0;
		{RX_LEN, RX_DATA, seen, ok} = '0;
		TX_RES = RAPI_RES_OK;
		repeat (4) @(negedge CLK);
		RST_N = 1;
		chk("idle", {REQ_BUSY, TX_BUSY, RX_BUSY, EV_VLD, TX_REQ}, 0);
		foreach (rows[i]) tx(rows[i]);
		rx(1'b1, 64'h0013_A200_4000_0001, 8'h28, 8'hFF, 8'd112);
		rx(1'b0, 64'h0000_0000_0000_ABCD, 8'h40, 8'h02, 8'd3);
		idle_wait();
		{REQ, REQ_FID, REQ_LEN} = {1'b1, 8'h0C, 8'h10};
		@(negedge CLK);
		REQ = 0;
		repeat (4) @(negedge CLK);
		RST_N = 0;
		@(negedge CLK);
		RST_N = 1;
		chk("reset", {rapi_if_i.h2d_valid, REQ_BUSY, TX_BUSY}, 0);
		$display("reset test done");
		tx(rows[0]);
		conclude();
	end
endmodule : tb_radio_api_data_frames
